/* File: design/sfrc_pkg.sv */
// shared constants for the serial flash reset control ends
package sfrc_pkg;
  localparam int CLOCK_MHZ = 25;
  localparam int CLOCK_PERIOD_NS = 1000 / CLOCK_MHZ;
  // times in their own units
  localparam int POWER_UP_DELAY_US = 300;
  localparam int DESELECT_TIME_NS = 50;
  localparam int RESET_SETUP_TIME_NS = 50;
  localparam int RESET_RECOVERY_TIME_US = 100;
  localparam int RESET_PULSE_WIDTH_NS = 200;
  localparam int RESET_HOLD_TIME_NS = 150;
  // cycle counts, least times rounded up
  localparam int POWER_UP_CYCLES = (POWER_UP_DELAY_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DESELECT_CYCLES = (DESELECT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_SETUP_CYCLES = (RESET_SETUP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_RECOVERY_CYCLES = (RESET_RECOVERY_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_WIDTH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int COUNT_WIDTH = 14;
  // opcodes
  localparam logic [7:0] SOFT_RESET_ENABLE_CMD = 8'h66;
  localparam logic [7:0] SOFT_RESET_EXECUTE_CMD = 8'h99;
  // configuration bit positions
  localparam int QUAD_MODE_BIT = 1;
  localparam int QUAD_COMMAND_MODE_BIT = 3;
  localparam int SHARED_PIN_RESET_ENABLE_BIT = 7;
  localparam logic [7:0] CONFIG1_RESET = 8'h00;
  localparam logic [7:0] CONFIG2_RESET = 8'h00;
  // link clock divider: half period in system cycles
  localparam int SCK_HALF_CYCLES = 4;
  typedef enum logic [4:0] {
    SFRC_POR = 5'h01,
    SFRC_READY = 5'h02,
    SFRC_QUALIFY = 5'h04,
    SFRC_RECOVER = 5'h08,
    SFRC_SOFT = 5'h10
  } sfrc_state_e;
  typedef enum logic [5:0] {
    SFRCH_POWER = 6'h01,
    SFRCH_IDLE = 6'h02,
    SFRCH_CMD = 6'h04,
    SFRCH_GAP = 6'h08,
    SFRCH_RST_LOW = 6'h10,
    SFRCH_RST_WAIT = 6'h20
  } sfrch_state_e;
endpackage

/* File: design/sfrc_link_if.sv */
// link pins between the flash device end and the host end
`timescale 1ns/1ns
interface sfrc_link_if;
  logic select_n;
  logic sck;
  logic data0;
  logic reset_pin_n;
  logic data3_host_out;
  logic data3_host_oe;
  logic data3_dev_out;
  logic data3_dev_oe;
  // resolved shared pin with internal pull-up
  logic shared_data3_reset_pin;
  assign shared_data3_reset_pin = data3_host_oe ? data3_host_out : (data3_dev_oe ? data3_dev_out : 1'b1);
  modport device (
    input select_n,
    input sck,
    input data0,
    input reset_pin_n,
    input data3_host_out,
    input data3_host_oe,
    input shared_data3_reset_pin,
    output data3_dev_out,
    output data3_dev_oe
  );
  modport host (
    output select_n,
    output sck,
    output data0,
    output reset_pin_n,
    output data3_host_out,
    output data3_host_oe,
    input shared_data3_reset_pin
  );
endinterface

/* File: design/sfrc_device.sv */
// flash device end: power-on, pin and software reset sequencing
`timescale 1ns/1ns
// How it works
// [R01] reset mid-operation leaves its target undefined
// [R02] pin reset ignored during software reset
// [R03] host stays deselected during power-up
// [R04] reset pins ignored during power-on
// [R05] host waits hold time after pin rises
// [R06] pin high setup time before new reset
// [R07] shared pin resets only when deselected, quad or non-quad
// [R08] long low pulse restores power-on register state
// [R09] recovery time before select accepted
// [R10] shared pin ignored during deselect time in quad mode
// [R11] selected means shared pin is data
// [R12] failed power-on makes pin reset full
// [R13] 66h then 99h performs software reset
// [R14] nonvolatile bit clear disables shared reset
// [R15] shared reset aborts, tristates, ignores commands
// [R16] host avoids low data3 during deselect
// [R17] device drives data3 high after quad read
// [R18] host drives data3 high after quad write
// [R19] non-quad host raises select within recovery
// [R20] lows qualified by counter against width
module sfrc_device (
  input wire logic clock,
  input wire logic reset_n,
  sfrc_link_if.device link,
  input wire logic power_up_ok,
  input wire logic config2_nonvolatile_reset_en,
  input wire logic quad_read_done,
  input wire logic [7:0] config1_write,
  input wire logic [7:0] config2_write,
  input wire logic config_write_en,
  output logic in_reset,
  output logic busy_abort,
  output logic ready,
  output logic [7:0] config1_volatile,
  output logic [7:0] config2_volatile,
  output logic soft_reset_done
);
  typedef struct packed {
    sfrc_pkg::sfrc_state_e state;
    logic [13:0] count;
    logic [13:0] low_count;
    logic [13:0] desel_count;
    logic [2:0] sel_sync;
    logic [2:0] rst_sync;
    logic [2:0] d3_sync;
    logic [2:0] sck_sync;
    logic [1:0] d0_sync;
    logic [7:0] shift;
    logic [2:0] bits;
    logic armed;
    logic drive_high;
    logic d3_oe;
    logic por_failed;
    logic full_por;
    logic in_reset;
    logic busy_abort;
    logic ready;
    logic [7:0] config1_volatile;
    logic [7:0] config2_volatile;
    logic soft_reset_done;
  } sfrc_dev_s;
  sfrc_dev_s cur;
  sfrc_dev_s next_cur;
  logic sel_n;
  logic rst_n_pin;
  logic d3;
  logic sck_rise;
  logic quad;
  logic shared_valid;
  logic pin_low;
  logic [7:0] byte_in;
  always_comb begin
    sel_n = cur.sel_sync[1];
    rst_n_pin = cur.rst_sync[1];
    d3 = cur.d3_sync[1];
    sck_rise = cur.sck_sync[1] & ~cur.sck_sync[2];
    quad = cur.config1_volatile[sfrc_pkg::QUAD_MODE_BIT] & cur.config2_volatile[sfrc_pkg::QUAD_COMMAND_MODE_BIT];
    // selected means data line 3, and in quad mode the deselect window masks it
    shared_valid = config2_nonvolatile_reset_en & sel_n & cur.sel_sync[2] &
                   (~quad | (cur.desel_count >= 14'(sfrc_pkg::DESELECT_CYCLES))); // [R07] [R10] [R11] [R14]
    pin_low = ~rst_n_pin | (shared_valid & ~d3);
    byte_in = {cur.shift[6:0], cur.d0_sync[1]};
    next_cur = cur;
    next_cur.sel_sync = {cur.sel_sync[1:0], link.select_n};
    next_cur.rst_sync = {cur.rst_sync[1:0], link.reset_pin_n};
    next_cur.d3_sync = {cur.d3_sync[1:0], link.shared_data3_reset_pin};
    next_cur.sck_sync = {cur.sck_sync[1:0], link.sck};
    next_cur.d0_sync = {cur.d0_sync[0], link.data0};
    next_cur.soft_reset_done = 1'b0;
    if (!sel_n) begin
      next_cur.desel_count = '0;
    end else if (cur.desel_count != 14'h3fff) begin
      next_cur.desel_count = cur.desel_count + 14'h0001;
    end
    // hold data3 high through the deselect time after a quad read
    if (quad_read_done) begin
      next_cur.drive_high = 1'b1; // [R17]
    end else if (!sel_n || cur.desel_count >= 14'(sfrc_pkg::DESELECT_CYCLES)) begin
      next_cur.drive_high = 1'b0;
    end
    if (config_write_en && cur.state == sfrc_pkg::SFRC_READY) begin
      next_cur.config1_volatile = config1_write;
      next_cur.config2_volatile = config2_write;
    end
    case (cur.state)
      sfrc_pkg::SFRC_POR: begin
        // pin levels are not looked at here
        next_cur.in_reset = 1'b1; // [R04]
        next_cur.ready = 1'b0;
        if (cur.count >= 14'(sfrc_pkg::POWER_UP_CYCLES - 1)) begin
          next_cur.por_failed = ~power_up_ok; // [R12]
          next_cur.full_por = 1'b0;
          next_cur.low_count = '0;
          next_cur.state = sfrc_pkg::SFRC_READY;
        end else begin
          next_cur.count = cur.count + 14'h0001;
        end
      end
      sfrc_pkg::SFRC_READY: begin
        next_cur.in_reset = 1'b0;
        next_cur.busy_abort = 1'b0;
        next_cur.ready = rst_n_pin;
        if (pin_low) begin
          next_cur.low_count = '0;
          next_cur.state = sfrc_pkg::SFRC_QUALIFY;
        end else if (!sel_n && sck_rise) begin
          next_cur.shift = byte_in;
          next_cur.bits = cur.bits + 3'h1;
          if (cur.bits == 3'h7) begin
            if (byte_in == sfrc_pkg::SOFT_RESET_ENABLE_CMD) begin
              next_cur.armed = 1'b1;
            end else if (byte_in == sfrc_pkg::SOFT_RESET_EXECUTE_CMD && cur.armed) begin
              next_cur.armed = 1'b0;
              next_cur.count = '0;
              next_cur.state = sfrc_pkg::SFRC_SOFT; // [R13]
            end else begin
              next_cur.armed = 1'b0;
            end
          end
        end else if (sel_n) begin
          next_cur.bits = '0;
        end
      end
      sfrc_pkg::SFRC_QUALIFY: begin
        // a short glitch returns to ready without effect
        if (!pin_low) begin
          next_cur.state = sfrc_pkg::SFRC_READY; // [R20]
        end else if (cur.low_count >= 14'(sfrc_pkg::RESET_PULSE_CYCLES - 1)) begin
          next_cur.count = '0;
          next_cur.in_reset = 1'b1;
          next_cur.busy_abort = 1'b1; // [R01] [R15]
          next_cur.ready = 1'b0;
          next_cur.armed = 1'b0;
          next_cur.bits = '0;
          next_cur.config1_volatile = sfrc_pkg::CONFIG1_RESET; // [R08]
          next_cur.config2_volatile = sfrc_pkg::CONFIG2_RESET;
          if (cur.por_failed) begin
            next_cur.state = sfrc_pkg::SFRC_POR; // [R12]
          end else begin
            next_cur.state = sfrc_pkg::SFRC_RECOVER;
          end
        end else begin
          next_cur.low_count = cur.low_count + 14'h0001;
        end
      end
      sfrc_pkg::SFRC_RECOVER: begin
        // commands ignored until recovery done and pin high
        next_cur.busy_abort = 1'b0;
        if (cur.count < 14'(sfrc_pkg::RESET_RECOVERY_CYCLES - 1)) begin
          next_cur.count = cur.count + 14'h0001; // [R09]
        end else if (rst_n_pin && (!shared_valid || d3)) begin
          next_cur.low_count = '0;
          next_cur.state = sfrc_pkg::SFRC_READY; // [R15]
        end
      end
      sfrc_pkg::SFRC_SOFT: begin
        // pin resets ignored while this runs
        next_cur.in_reset = 1'b1; // [R02]
        next_cur.ready = 1'b0;
        next_cur.config1_volatile = sfrc_pkg::CONFIG1_RESET;
        next_cur.config2_volatile = sfrc_pkg::CONFIG2_RESET;
        if (cur.count >= 14'(sfrc_pkg::RESET_RECOVERY_CYCLES - 1)) begin
          next_cur.soft_reset_done = 1'b1;
          next_cur.state = sfrc_pkg::SFRC_READY;
        end else begin
          next_cur.count = cur.count + 14'h0001;
        end
      end
      default: begin
        next_cur.state = sfrc_pkg::SFRC_POR;
      end
    endcase
    next_cur.in_reset = (next_cur.state != sfrc_pkg::SFRC_READY) & (next_cur.state != sfrc_pkg::SFRC_QUALIFY);
    // data line 3 driven high only after a quad read, never in reset
    next_cur.d3_oe = next_cur.drive_high & ~next_cur.in_reset; // [R15] [R17]
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '{state: sfrc_pkg::SFRC_POR, sel_sync: 3'h7, rst_sync: 3'h7, d3_sync: 3'h7,
               in_reset: 1'b1, desel_count: 14'h3fff, default: '0};
    end else begin
      cur <= next_cur;
    end
  end
  assign link.data3_dev_out = cur.d3_oe;
  assign link.data3_dev_oe = cur.d3_oe;
  assign in_reset = cur.in_reset;
  assign busy_abort = cur.busy_abort;
  assign ready = cur.ready;
  assign config1_volatile = cur.config1_volatile;
  assign config2_volatile = cur.config2_volatile;
  assign soft_reset_done = cur.soft_reset_done;
endmodule

/* File: design/sfrc_host.sv */
// host end: power-up wait, pin reset pulses and software reset command
`timescale 1ns/1ns
module sfrc_host (
  input wire logic clock,
  input wire logic reset_n,
  sfrc_link_if.host link,
  input wire logic hw_reset_req,
  input wire logic soft_reset_req,
  input wire logic use_shared_pin,
  input wire logic quad_write_done,
  output logic busy,
  output logic link_ready
);
  typedef struct packed {
    sfrc_pkg::sfrch_state_e state;
    logic [13:0] count;
    logic [2:0] div;
    logic sck;
    logic [15:0] shift;
    logic [4:0] bits;
    logic select_n;
    logic reset_pin_n;
    logic d3_out;
    logic d3_oe;
    logic d0;
    logic busy;
    logic link_ready;
  } sfrc_host_s;
  sfrc_host_s cur;
  sfrc_host_s next_cur;
  logic half_tick;
  always_comb begin
    half_tick = cur.div == 3'(sfrc_pkg::SCK_HALF_CYCLES - 1);
    next_cur = cur;
    next_cur.div = half_tick ? 3'h0 : cur.div + 3'h1;
    case (cur.state)
      sfrc_pkg::SFRCH_POWER: begin
        next_cur.select_n = 1'b1; // [R03]
        next_cur.busy = 1'b1;
        if (cur.count >= 14'(sfrc_pkg::POWER_UP_CYCLES - 1)) begin
          next_cur.count = '0;
          next_cur.state = sfrc_pkg::SFRCH_GAP;
        end else begin
          next_cur.count = cur.count + 14'h0001;
        end
      end
      sfrc_pkg::SFRCH_IDLE: begin
        next_cur.busy = 1'b0;
        next_cur.link_ready = 1'b1;
        next_cur.d3_oe = 1'b0;
        if (hw_reset_req) begin
          next_cur.count = '0;
          next_cur.busy = 1'b1;
          next_cur.link_ready = 1'b0;
          next_cur.select_n = 1'b1; // [R19]
          next_cur.state = sfrc_pkg::SFRCH_RST_LOW;
        end else if (soft_reset_req) begin
          next_cur.shift = {sfrc_pkg::SOFT_RESET_ENABLE_CMD, sfrc_pkg::SOFT_RESET_EXECUTE_CMD}; // [R13]
          next_cur.bits = '0;
          next_cur.busy = 1'b1;
          next_cur.link_ready = 1'b0;
          next_cur.div = '0;
          next_cur.select_n = 1'b0;
          next_cur.d0 = sfrc_pkg::SOFT_RESET_ENABLE_CMD[7];
          next_cur.state = sfrc_pkg::SFRCH_CMD;
        end else if (quad_write_done) begin
          next_cur.d3_out = 1'b1; // [R16] [R18]
          next_cur.d3_oe = 1'b1;
          next_cur.count = '0;
          next_cur.state = sfrc_pkg::SFRCH_GAP;
        end
      end
      sfrc_pkg::SFRCH_CMD: begin
        // mode 0: data set on falling edge, device samples rising
        if (half_tick) begin
          next_cur.sck = ~cur.sck;
          if (cur.sck) begin
            next_cur.bits = cur.bits + 5'h01;
            next_cur.shift = {cur.shift[14:0], 1'b0};
            next_cur.d0 = cur.shift[14];
            if (cur.bits == 5'h07 || cur.bits == 5'h0f) begin
              next_cur.select_n = 1'b1;
              next_cur.count = '0;
              next_cur.state = (cur.bits == 5'h0f) ? sfrc_pkg::SFRCH_RST_WAIT : sfrc_pkg::SFRCH_GAP;
            end
          end
        end
      end
      sfrc_pkg::SFRCH_GAP: begin
        // deselect and setup spacing before next activity
        next_cur.sck = 1'b0;
        if (cur.count >= 14'(sfrc_pkg::DESELECT_CYCLES + sfrc_pkg::RESET_SETUP_CYCLES)) begin // [R06]
          next_cur.d3_oe = 1'b0;
          next_cur.div = '0;
          if (cur.bits == 5'h08) begin
            next_cur.select_n = 1'b0;
            next_cur.d0 = cur.shift[15];
            next_cur.state = sfrc_pkg::SFRCH_CMD;
          end else begin
            next_cur.bits = '0;
            next_cur.state = sfrc_pkg::SFRCH_IDLE;
          end
        end else begin
          next_cur.count = cur.count + 14'h0001;
        end
      end
      sfrc_pkg::SFRCH_RST_LOW: begin
        if (use_shared_pin) begin
          next_cur.d3_out = 1'b0;
          next_cur.d3_oe = 1'b1;
        end else begin
          next_cur.reset_pin_n = 1'b0;
        end
        if (cur.count >= 14'(sfrc_pkg::RESET_PULSE_CYCLES + 1)) begin
          next_cur.reset_pin_n = 1'b1;
          next_cur.d3_out = 1'b1;
          next_cur.state = sfrc_pkg::SFRCH_RST_WAIT;
        end
        next_cur.count = cur.count + 14'h0001;
      end
      sfrc_pkg::SFRCH_RST_WAIT: begin
        // select held high for recovery and hold times
        next_cur.select_n = 1'b1;
        if (cur.count >= 14'(sfrc_pkg::RESET_RECOVERY_CYCLES + sfrc_pkg::RESET_HOLD_CYCLES)) begin // [R05] [R09]
          next_cur.d3_oe = 1'b0;
          next_cur.count = '0;
          next_cur.bits = '0;
          next_cur.state = sfrc_pkg::SFRCH_GAP;
        end else begin
          next_cur.count = cur.count + 14'h0001;
        end
      end
      default: begin
        next_cur.state = sfrc_pkg::SFRCH_POWER;
      end
    endcase
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '{state: sfrc_pkg::SFRCH_POWER, select_n: 1'b1, reset_pin_n: 1'b1, d3_out: 1'b1,
               busy: 1'b1, default: '0};
    end else begin
      cur <= next_cur;
    end
  end
  assign link.select_n = cur.select_n;
  assign link.sck = cur.sck;
  assign link.data0 = cur.d0;
  assign link.reset_pin_n = cur.reset_pin_n;
  assign link.data3_host_out = cur.d3_out;
  assign link.data3_host_oe = cur.d3_oe;
  assign busy = cur.busy;
  assign link_ready = cur.link_ready;
endmodule

/* File: test/sfrc_link_monitor.sv */
// link protocol assertions between the host and device ends
`timescale 1ns/1ns
module sfrc_link_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic select_n,
  input wire logic sck,
  input wire logic data0,
  input wire logic reset_pin_n,
  input wire logic data3_host_out,
  input wire logic data3_host_oe,
  input wire logic data3_dev_oe
);
  int por_cnt;
  int since_fall;
  int since_low;
  int rises;
  logic sck_q;
  logic low_q;
  logic [7:0] shifted;
  logic host_low;
  // either reset source pulled low by the host
  assign host_low = !reset_pin_n || (data3_host_oe && !data3_host_out);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      por_cnt <= 0;
      since_fall <= 100000;
      since_low <= 100000;
      rises <= 0;
      sck_q <= 1'b0;
      low_q <= 1'b0;
      shifted <= 8'h00;
    end else begin
      sck_q <= sck;
      low_q <= host_low;
      if (por_cnt < sfrc_pkg::POWER_UP_CYCLES) por_cnt <= por_cnt + 1;
      if (host_low && !low_q) since_fall <= 0;
      else if (since_fall < 100000) since_fall <= since_fall + 1;
      if (host_low) since_low <= 0;
      else if (since_low < 100000) since_low <= since_low + 1;
      if (select_n) rises <= 0;
      else if (sck && !sck_q) begin
        rises <= rises + 1;
        shifted <= {shifted[6:0], data0};
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_pulse_low;
    !reset_pin_n [*6];
  endsequence
  sequence s_setup_high;
    reset_pin_n [*2];
  endsequence
  sequence s_gap_clean;
    !(data3_host_oe && !data3_host_out) [*2];
  endsequence
  a_por_deselect: assert property (por_cnt < sfrc_pkg::POWER_UP_CYCLES |-> select_n)
    else $error("select low in power-up");
  a_pulse_width: assert property ($fell(reset_pin_n) |-> s_pulse_low)
    else $error("reset pulse too short");
  a_setup_high: assert property ($rose(reset_pin_n) |-> s_setup_high)
    else $error("reset pin high too briefly");
  a_low_deselected: assert property (host_low |-> select_n)
    else $error("select low while reset low");
  a_hold_select: assert property (since_low < sfrc_pkg::RESET_HOLD_CYCLES |-> select_n)
    else $error("select low within hold time");
  a_recovery_select: assert property (since_fall < sfrc_pkg::RESET_RECOVERY_CYCLES |-> select_n)
    else $error("select low within recovery");
  a_no_contention: assert property (!(data3_host_oe && data3_dev_oe))
    else $error("both ends drive data line 3");
  a_gap_clean: assert property ($rose(select_n) |-> s_gap_clean)
    else $error("data line 3 low in deselect gap");
  a_frame_count: assert property ($rose(select_n) |-> rises == 8)
    else $error("frame not eight clocks");
  a_frame_byte: assert property ($rose(select_n) |->
    shifted == sfrc_pkg::SOFT_RESET_ENABLE_CMD || shifted == sfrc_pkg::SOFT_RESET_EXECUTE_CMD)
    else $error("unexpected frame byte");
endmodule

/* File: test/serial_flash_reset_control_tb.sv */
// bench for the host and device reset ends
`timescale 1ns/1ns
module serial_flash_reset_control_tb;
  logic clock, reset_n, nv_en, quad_read_done, config_write_en, hw_reset_req, soft_reset_req, use_shared_pin;
  logic [7:0] config1_write, config2_write, config1_volatile, config2_volatile;
  logic in_reset, busy_abort, ready, soft_reset_done, busy, link_ready, b_in_reset, b_ready;
  logic saw_rst, saw_done, saw_b, saw_hi, saw_ab, qw_done;
  int err_total, check_count;
  sfrc_link_if link();
  sfrc_link_if link_b();
  sfrc_device u_sfrc_device (.clock(clock), .reset_n(reset_n), .link(link), .power_up_ok(1'b1),
    .config2_nonvolatile_reset_en(nv_en), .quad_read_done(quad_read_done), .config1_write(config1_write),
    .config2_write(config2_write), .config_write_en(config_write_en), .in_reset(in_reset),
    .busy_abort(busy_abort), .ready(ready), .config1_volatile(config1_volatile),
    .config2_volatile(config2_volatile), .soft_reset_done(soft_reset_done));
  sfrc_host u_sfrc_host (.clock(clock), .reset_n(reset_n), .link(link), .hw_reset_req(hw_reset_req),
    .soft_reset_req(soft_reset_req), .use_shared_pin(use_shared_pin), .quad_write_done(qw_done),
    .busy(busy), .link_ready(link_ready));
  // second device with a failed power-on, its pins driven by the bench
  sfrc_device u_sfrc_device_b (.clock(clock), .reset_n(reset_n), .link(link_b), .power_up_ok(1'b0),
    .config2_nonvolatile_reset_en(nv_en), .quad_read_done(1'b0), .config1_write(config1_write),
    .config2_write(config2_write), .config_write_en(config_write_en), .in_reset(b_in_reset),
    .busy_abort(), .ready(b_ready), .config1_volatile(), .config2_volatile(), .soft_reset_done());
  sfrc_link_monitor u_sfrc_link_monitor (.clock(clock), .reset_n(reset_n), .select_n(link.select_n),
    .sck(link.sck), .data0(link.data0), .reset_pin_n(link.reset_pin_n), .data3_host_out(link.data3_host_out),
    .data3_host_oe(link.data3_host_oe), .data3_dev_oe(link.data3_dev_oe));
  ////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (in_reset === 1'b1) saw_rst <= 1'b1;
    if (soft_reset_done === 1'b1) saw_done <= 1'b1;
    if (busy_abort === 1'b1) saw_ab <= 1'b1;
    if (b_in_reset === 1'b1) saw_b <= 1'b1;
    if (link.data3_dev_oe === 1'b1 && link.data3_dev_out === 1'b1) saw_hi <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_on(input int sel, input int limit);
    int n;
    n = 0;
    while (!((sel == 0) ? link_ready === 1'b1 : b_ready === 1'b1) && n < limit) begin
      @(negedge clock);
      n++;
    end
    check(n < limit, 8'h01, "wait bound");
  endtask
  task automatic request(input logic hw);
    @(negedge clock);
    {saw_rst, saw_done, saw_ab} = 3'b000;
    hw_reset_req = hw;
    soft_reset_req = !hw;
    @(negedge clock);
    {hw_reset_req, soft_reset_req} = 2'b00;
  endtask
  task automatic write_cfg(input logic [7:0] c1, input logic [7:0] c2);
    @(negedge clock);
    config1_write = c1;
    config2_write = c2;
    config_write_en = 1'b1;
    @(negedge clock);
    config_write_en = 1'b0;
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #2400000;
    err_total++;
    report_and_stop;
  end
  initial begin
    {reset_n, hw_reset_req, soft_reset_req, quad_read_done, config_write_en, use_shared_pin, qw_done} = '0;
    {saw_rst, saw_done, saw_b, saw_hi, saw_ab} = '0;
    nv_en = 1'b1;
    config1_write = 8'h00;
    config2_write = 8'h00;
    err_total = 0;
    check_count = 0;
    link_b.select_n = 1'b1;
    link_b.sck = 1'b0;
    link_b.data0 = 1'b0;
    link_b.reset_pin_n = 1'b0;
    link_b.data3_host_out = 1'b1;
    link_b.data3_host_oe = 1'b0;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    check(in_reset, 8'h01, "device in power-up");
    check(busy, 8'h01, "host busy in power-up");
    repeat (7700) @(negedge clock);
    check(b_in_reset, 8'h01, "pin held low past power-up");
    link_b.reset_pin_n = 1'b1;
    wait_on(1, 9000);
    wait_on(0, 100);
    check(ready, 8'h01, "device ready");
    check(config1_volatile, sfrc_pkg::CONFIG1_RESET, "config1 reset value");
    check(config2_volatile, sfrc_pkg::CONFIG2_RESET, "config2 reset value");
    end_test("power up");
    write_cfg(8'h02, 8'h08);
    check(config1_volatile, 8'h02, "config1 written");
    request(1'b1);
    repeat (12) @(negedge clock);
    check(in_reset, 8'h01, "pin reset started");
    write_cfg(8'h55, 8'h55);
    wait_on(0, 4000);
    check(config1_volatile, sfrc_pkg::CONFIG1_RESET, "config1 restored");
    check(config2_volatile, sfrc_pkg::CONFIG2_RESET, "config2 restored");
    check(saw_ab, 8'h01, "operation aborted");
    end_test("pin reset");
    request(1'b0);
    wait_on(0, 6000);
    check(saw_done, 8'h01, "soft reset done");
    check(saw_rst, 8'h01, "in reset during soft reset");
    end_test("soft reset");
    nv_en = 1'b0;
    use_shared_pin = 1'b1;
    request(1'b1);
    wait_on(0, 4000);
    check(saw_rst, 8'h00, "shared reset disabled");
    nv_en = 1'b1;
    request(1'b1);
    wait_on(0, 4000);
    check(saw_rst, 8'h01, "shared reset when not quad");
    end_test("shared pin");
    write_cfg(8'h02, 8'h08);
    @(negedge clock);
    quad_read_done = 1'b1;
    @(negedge clock);
    quad_read_done = 1'b0;
    repeat (4) @(negedge clock);
    check(saw_hi, 8'h01, "device drives data line 3 high");
    saw_rst = 1'b0;
    qw_done = 1'b1;
    @(negedge clock);
    qw_done = 1'b0;
    check({link.data3_host_oe, link.shared_data3_reset_pin}, 8'h03, "host holds data line 3 high");
    wait_on(0, 100);
    repeat (10) @(negedge clock);
    check(link.data3_host_oe, 8'h00, "host releases data line 3");
    check(saw_rst, 8'h00, "no reset after quad write");
    end_test("quad read gap");
    repeat (10) @(negedge clock);
    saw_b = 1'b0;
    link_b.reset_pin_n = 1'b0;
    repeat (3) @(negedge clock);
    link_b.reset_pin_n = 1'b1;
    repeat (20) @(negedge clock);
    check(saw_b, 8'h00, "short pulse ignored");
    link_b.reset_pin_n = 1'b0;
    repeat (10) @(negedge clock);
    link_b.reset_pin_n = 1'b1;
    repeat (3000) @(negedge clock);
    check(b_in_reset, 8'h01, "failed power-on reruns full reset");
    wait_on(1, 6000);
    end_test("failed power-on");
    report_and_stop;
  end
endmodule
